//--- hw/periph_irq_defines.svh
// offsets, field positions, reset values of the peripheral flag block
// assumes a 32-bit wishbone slave decoding byte address bits [7:0]
`ifndef PERIPH_IRQ_DEFINES_SVH
`define PERIPH_IRQ_DEFINES_SVH

`define ADDR_FLAGS 8'h00
`define ADDR_FLAG_EN 8'h04
`define ADDR_CTRL 8'h08
`define ADDR_EVT_STATUS 8'h0C
`define ADDR_EVT_MASK 8'h10

`define BIT_CONV_DONE 6
`define BIT_CAPCMP 5
`define BIT_CMP_B 4
`define BIT_CMP_A 3
`define BIT_PERIOD_MATCH 1
`define BIT_WIDE_OVF 0

`define BIT_GLOBAL_EN 0
`define BIT_PERIPH_EN 1

`define IMPL_FULL 8'h7B
`define IMPL_REDUCED 8'h19
`define FLAGS_RESET 8'h00
`define CTRL_RESET 2'h0
`define WIDE_TIMER_TOP 16'hFFFF
`define WIDE_TIMER_ZERO 16'h0000

`endif

//--- hw/periph_irq_pkg.sv
// types shared by the peripheral flag block
// assumes the defines header for all numeric constants
package periph_irq_pkg;

    typedef enum logic [1:0] {
        CAPCMP_OFF,
        CAPCMP_CAPTURE,
        CAPCMP_COMPARE,
        CAPCMP_PWM
    } capcmp_mode_t;

    typedef logic [7:0] flag_vec_t;

endpackage : periph_irq_pkg

//--- hw/flag_bit.sv
// one flag bit and its sticky event-status bit
// assumes set, write and clear strobes from logic on ref_clk
`timescale 1ns/1ps
`default_nettype none

module flag_bit (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic impl,
    input wire logic setEvt,
    input wire logic wrEn,
    input wire logic wrVal,
    input wire logic clrSticky,
    output logic flagQ,
    output logic stickyQ
);

    // set beats a same-cycle software write or read-clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flagQ <= 1'b0;
        end else if (!impl) begin
            flagQ <= 1'b0;
        end else if (setEvt) begin
            flagQ <= 1'b1;
        end else if (wrEn) begin
            flagQ <= wrVal;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stickyQ <= 1'b0;
        end else if (!impl) begin
            stickyQ <= 1'b0;
        end else if (setEvt) begin
            stickyQ <= 1'b1;
        end else if (clrSticky) begin
            stickyQ <= 1'b0;
        end
    end

endmodule : flag_bit

`default_nettype wire

//--- hw/peripheral_interrupt_flags.sv
// peripheral interrupt flag register with wishbone classic slave
// assumes peripheral strobes on ref_clk; comparators and strap async
`timescale 1ns/1ps
`default_nettype none
`include "periph_irq_defines.svh"

module peripheral_interrupt_flags
    import periph_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatWr,
    output logic [31:0] wbDatRd,
    output logic wbAck,
    output logic irqOut,
    input wire logic reducedStrap,
    input wire logic convDone,
    input wire capcmp_mode_t capcmpMode,
    input wire logic captureStrobe,
    input wire logic [15:0] wideTimerValue,
    input wire logic [15:0] compareValue,
    input wire logic [7:0] timerCount,
    input wire logic [7:0] periodValue,
    input wire logic cmpAOut,
    input wire logic cmpBOut
);

    flag_vec_t flags;
    flag_vec_t sticky;
    flag_vec_t implMask;
    flag_vec_t setVec;
    flag_vec_t flagWrVec;
    flag_vec_t clrVec;
    flag_vec_t flagEn_r;
    flag_vec_t evtMask_r;
    logic [1:0] ctrl_r;
    logic [1:0] strapSync_r;
    logic [1:0] cmpASync_r;
    logic [1:0] cmpBSync_r;
    logic cmpAPrev_r;
    logic cmpBPrev_r;
    logic [15:0] widePrev_r;
    logic cmpMatchPrev_r;
    logic periodMatchPrev_r;
    logic [31:0] datRd_nxt;
    logic irq_nxt;
    logic busAct;
    logic takeReq;
    logic wrDone;
    logic rdDone;
    logic cmpMatch;
    logic periodMatch;
    logic capcmpSet;
    logic wideOvf;
    logic cmpAChg;
    logic cmpBChg;

    // strap and comparator outputs are asynchronous to ref_clk
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strapSync_r <= 2'h0;
            cmpASync_r <= 2'h0;
            cmpBSync_r <= 2'h0;
        end else begin
            strapSync_r <= {strapSync_r[0], reducedStrap};
            cmpASync_r <= {cmpASync_r[0], cmpAOut};
            cmpBSync_r <= {cmpBSync_r[0], cmpBOut};
        end
    end

    // reduced variant drops converter, capture/compare, period flags
    assign implMask = strapSync_r[1] ? `IMPL_REDUCED : `IMPL_FULL;

    // history for edge and rollover detection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpAPrev_r <= 1'b0;
            cmpBPrev_r <= 1'b0;
            widePrev_r <= `WIDE_TIMER_ZERO;
            cmpMatchPrev_r <= 1'b0;
            periodMatchPrev_r <= 1'b0;
        end else begin
            cmpAPrev_r <= cmpASync_r[1];
            cmpBPrev_r <= cmpBSync_r[1];
            widePrev_r <= wideTimerValue;
            cmpMatchPrev_r <= cmpMatch;
            periodMatchPrev_r <= periodMatch;
        end
    end

    // a held match would retrigger forever; only its start counts
    assign cmpMatch = (capcmpMode == CAPCMP_COMPARE) &&
        (wideTimerValue == compareValue);
    assign periodMatch = (timerCount == periodValue);
    assign capcmpSet = (capcmpMode == CAPCMP_CAPTURE && captureStrobe)
        || (cmpMatch && !cmpMatchPrev_r);
    assign wideOvf = (widePrev_r == `WIDE_TIMER_TOP) &&
        (wideTimerValue == `WIDE_TIMER_ZERO);
    assign cmpAChg = cmpASync_r[1] != cmpAPrev_r;
    assign cmpBChg = cmpBSync_r[1] != cmpBPrev_r;

    // events go straight to the flags, no enable in the path
    always_comb begin
        setVec = 8'h00;
        setVec[`BIT_CONV_DONE] = convDone;
        setVec[`BIT_CAPCMP] = capcmpSet;
        setVec[`BIT_CMP_B] = cmpBChg;
        setVec[`BIT_CMP_A] = cmpAChg;
        setVec[`BIT_PERIOD_MATCH] = periodMatch && !periodMatchPrev_r;
        setVec[`BIT_WIDE_OVF] = wideOvf;
    end

    // bus: one wait state, then ack for one cycle
    assign busAct = wbCyc && wbStb;
    assign takeReq = busAct && !wbAck;
    assign wrDone = busAct && wbAck && wbWe && wbSel[0];
    assign rdDone = busAct && wbAck && !wbWe;

    // writes land at the edge where the master sees ack
    assign flagWrVec = (wrDone && wbAdr == `ADDR_FLAGS) ? 8'hFF : 8'h00;

    // clear only what the returned word showed, so a later event stays
    assign clrVec = (rdDone && wbAdr == `ADDR_EVT_STATUS) ?
        wbDatRd[7:0] : 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            flag_bit u_bit (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .impl(implMask[gi]),
                .setEvt(setVec[gi]),
                .wrEn(flagWrVec[gi]),
                .wrVal(wbDatWr[gi]),
                .clrSticky(clrVec[gi]),
                .flagQ(flags[gi]),
                .stickyQ(sticky[gi])
            );
        end
    endgenerate

    // enable and mask registers follow the flag layout
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flagEn_r <= `FLAGS_RESET;
            evtMask_r <= `FLAGS_RESET;
            ctrl_r <= `CTRL_RESET;
        end else if (wrDone) begin
            if (wbAdr == `ADDR_FLAG_EN) begin
                flagEn_r <= wbDatWr[7:0] & implMask;
            end else if (wbAdr == `ADDR_EVT_MASK) begin
                evtMask_r <= wbDatWr[7:0] & implMask;
            end else if (wbAdr == `ADDR_CTRL) begin
                ctrl_r <= wbDatWr[1:0];
            end
        end
    end

    // unmapped addresses read zero and ignore writes
    always_comb begin
        datRd_nxt = 32'h0000_0000;
        if (wbAdr == `ADDR_FLAGS) begin
            datRd_nxt[7:0] = flags & implMask;
        end else if (wbAdr == `ADDR_FLAG_EN) begin
            datRd_nxt[7:0] = flagEn_r & implMask;
        end else if (wbAdr == `ADDR_CTRL) begin
            datRd_nxt[1:0] = ctrl_r;
        end else if (wbAdr == `ADDR_EVT_STATUS) begin
            datRd_nxt[7:0] = sticky & implMask;
        end else if (wbAdr == `ADDR_EVT_MASK) begin
            datRd_nxt[7:0] = evtMask_r & implMask;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wbAck <= 1'b0;
            wbDatRd <= 32'h0000_0000;
        end else begin
            wbAck <= takeReq;
            wbDatRd <= (takeReq && !wbWe) ? datRd_nxt : 32'h0000_0000;
        end
    end

    // both enable stages gate the flag path and the sticky path
    assign irq_nxt = ctrl_r[`BIT_GLOBAL_EN] && ctrl_r[`BIT_PERIPH_EN] &&
        (|(flags & flagEn_r) || |(sticky & evtMask_r));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= irq_nxt;
        end
    end

    property p_unimpl_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        flags[7] == 1'b0 && flags[2] == 1'b0 && sticky[7] == 1'b0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented flag bit set");

    property p_reduced_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        strapSync_r[1] && $past(strapSync_r[1]) |->
            (flags & (`IMPL_FULL & ~`IMPL_REDUCED)) == 8'h00;
    endproperty
    a_reduced_zero: assert property (p_reduced_zero)
        else $error("absent flag set on reduced variant");

    property p_set_wins;
        @(posedge ref_clk) disable iff (!rst_n)
        convDone && implMask[`BIT_CONV_DONE] |=>
            flags[`BIT_CONV_DONE] && sticky[`BIT_CONV_DONE];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("conversion event lost");

    property p_flags_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        !(wrDone && wbAdr == `ADDR_FLAGS) && implMask == $past(implMask)
            |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("flag cleared without software write");

    property p_irq_gated;
        @(posedge ref_clk) disable iff (!rst_n)
        !(ctrl_r[`BIT_GLOBAL_EN] && ctrl_r[`BIT_PERIPH_EN]) |=> !irqOut;
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("interrupt without both enables");

    property p_cmp_b;
        @(posedge ref_clk) disable iff (!rst_n)
        cmpBChg |=> flags[`BIT_CMP_B];
    endproperty
    a_cmp_b: assert property (p_cmp_b)
        else $error("comparator b change not flagged");

    property p_cmp_a;
        @(posedge ref_clk) disable iff (!rst_n)
        $changed(cmpASync_r[1]) |=> flags[`BIT_CMP_A];
    endproperty
    a_cmp_a: assert property (p_cmp_a)
        else $error("comparator a change not flagged");

    property p_pwm_quiet;
        @(posedge ref_clk) disable iff (!rst_n)
        capcmpMode == CAPCMP_PWM |-> !capcmpSet;
    endproperty
    a_pwm_quiet: assert property (p_pwm_quiet)
        else $error("capture/compare set in pwm mode");

    property p_rollover;
        @(posedge ref_clk) disable iff (!rst_n)
        wideTimerValue == `WIDE_TIMER_ZERO &&
            $past(wideTimerValue) == `WIDE_TIMER_TOP |=>
            flags[`BIT_WIDE_OVF];
    endproperty
    a_rollover: assert property (p_rollover)
        else $error("wide timer rollover not flagged");

    property p_period;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(periodMatch) && implMask[`BIT_PERIOD_MATCH] |=>
            flags[`BIT_PERIOD_MATCH];
    endproperty
    a_period: assert property (p_period)
        else $error("period match not flagged");

    property p_ack_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
        takeReq |=> wbAck ##1 !wbAck;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack not a single cycle after request");

    property p_capture;
        @(posedge ref_clk) disable iff (!rst_n)
        capcmpMode == CAPCMP_CAPTURE && captureStrobe &&
            implMask[`BIT_CAPCMP] |=> flags[`BIT_CAPCMP];
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture not flagged");

    property p_compare;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(cmpMatch) && implMask[`BIT_CAPCMP] |=> flags[`BIT_CAPCMP];
    endproperty
    a_compare: assert property (p_compare)
        else $error("compare match not flagged");

    // a same-cycle event may legally keep a bit, so only quiet cycles
    property p_flag_write;
        @(posedge ref_clk) disable iff (!rst_n)
        wrDone && wbAdr == `ADDR_FLAGS && setVec == 8'h00 |=>
            flags == ($past(wbDatWr[7:0]) & $past(implMask));
    endproperty
    a_flag_write: assert property (p_flag_write)
        else $error("flag write did not land");

    property p_status_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        rdDone && wbAdr == `ADDR_EVT_STATUS && setVec == 8'h00 |=>
            (sticky & $past(wbDatRd[7:0])) == 8'h00;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("returned status bits not cleared");

    property p_irq_raise;
        @(posedge ref_clk) disable iff (!rst_n)
        ctrl_r[`BIT_GLOBAL_EN] && ctrl_r[`BIT_PERIPH_EN] &&
            (|(flags & flagEn_r)) |=> irqOut;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("enabled flag gave no interrupt");

    property p_rd_unimpl;
        @(posedge ref_clk) disable iff (!rst_n)
        wbAck && $past(wbAdr) == `ADDR_FLAGS |->
            wbDatRd[7] == 1'b0 && wbDatRd[2] == 1'b0 &&
            wbDatRd[31:8] == 24'h000000;
    endproperty
    a_rd_unimpl: assert property (p_rd_unimpl)
        else $error("unimplemented flag bit read as one");

endmodule : peripheral_interrupt_flags

`default_nettype wire

//--- verification/periph_model.sv
// event sources standing beside the flag block: adc, capture/compare,
// two comparators, 8-bit and 16-bit timers; assumes bench sends one kick
`timescale 1ns/1ps
`default_nettype none

module periph_model
    import periph_irq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic evGo,
    input wire logic [2:0] evKind,
    output logic convDone,
    output var capcmp_mode_t capcmpMode,
    output logic captureStrobe,
    output logic [15:0] wideTimerValue,
    output logic [15:0] compareValue,
    output logic [7:0] timerCount,
    output logic [7:0] periodValue,
    output logic cmpAOut,
    output logic cmpBOut
);
    logic rollPend;
    logic [7:0] hit;

    assign hit = evGo ? (8'h01 << evKind) : 8'h00;
    // idle timer value kept apart from both compare and top values
    assign compareValue = 16'h0F0F;
    assign periodValue = 8'h80;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            convDone <= 1'b0;
            captureStrobe <= 1'b0;
            timerCount <= 8'h00;
            rollPend <= 1'b0;
            wideTimerValue <= 16'h1234;
            capcmpMode <= CAPCMP_OFF;
            cmpAOut <= 1'b0;
            cmpBOut <= 1'b0;
        end else begin
            convDone <= hit[0];
            captureStrobe <= hit[1] | hit[7];
            timerCount <= hit[5] ? 8'h80 : 8'h00;
            rollPend <= hit[6];
            wideTimerValue <= rollPend ? 16'h0000 : hit[6] ? 16'hFFFF :
                hit[2] ? 16'h0F0F : 16'h1234;
            if (hit[1]) capcmpMode <= CAPCMP_CAPTURE;
            if (hit[2]) capcmpMode <= CAPCMP_COMPARE;
            if (hit[7]) capcmpMode <= CAPCMP_PWM;
            if (hit[3]) cmpBOut <= !cmpBOut;
            if (hit[4]) cmpAOut <= !cmpAOut;
        end
    end
endmodule : periph_model

`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the peripheral flag block
// assumes the event model and the defines header
`timescale 1ns/1ps
`default_nettype none
`include "periph_irq_defines.svh"

module tb;
    import periph_irq_pkg::*;
    logic ref_clk = 0, rst_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
    logic [7:0] wbAdr = 0;
    logic [3:0] wbSel = 0;
    logic [31:0] wbDatWr = 0, wbDatRd, q;
    logic wbAck, irqOut, reducedStrap = 0, evGo = 0;
    logic [2:0] evKind = 0;
    logic convDone, captureStrobe, cmpAOut, cmpBOut;
    capcmp_mode_t capcmpMode;
    logic [15:0] wideTimerValue, compareValue;
    logic [7:0] timerCount, periodValue;
    int num_errors = 0, num_checks = 0;
    integer seed = 32'h169EFFAA;
    // last kind is a capture in pwm mode: no flag expected
    int evBit[8] = '{'h40, 'h20, 'h20, 'h10, 'h08, 'h02, 'h01, 'h00};
    int expF = 0, expS = 0, impl = 'h7B;

    always #5 ref_clk = ~ref_clk;

    peripheral_interrupt_flags u_peripheral_interrupt_flags (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wbCyc(wbCyc),
        .wbStb(wbStb),
        .wbWe(wbWe),
        .wbAdr(wbAdr),
        .wbSel(wbSel),
        .wbDatWr(wbDatWr),
        .wbDatRd(wbDatRd),
        .wbAck(wbAck),
        .irqOut(irqOut),
        .reducedStrap(reducedStrap),
        .convDone(convDone),
        .capcmpMode(capcmpMode),
        .captureStrobe(captureStrobe),
        .wideTimerValue(wideTimerValue),
        .compareValue(compareValue),
        .timerCount(timerCount),
        .periodValue(periodValue),
        .cmpAOut(cmpAOut),
        .cmpBOut(cmpBOut)
    );
    periph_model u_periph_model (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .evGo(evGo),
        .evKind(evKind),
        .convDone(convDone),
        .capcmpMode(capcmpMode),
        .captureStrobe(captureStrobe),
        .wideTimerValue(wideTimerValue),
        .compareValue(compareValue),
        .timerCount(timerCount),
        .periodValue(periodValue),
        .cmpAOut(cmpAOut),
        .cmpBOut(cmpBOut)
    );

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input int e);
        num_checks++;
        if (got !== 32'(e)) begin
            $display("Error t=%0t got %h exp %h", $time, got, 32'(e));
            num_errors++;
        end
    endtask : chk

    task automatic chkIrq(input logic e);
        num_checks++;
        if (irqOut !== e) begin
            $display("Error t=%0t got %h exp %h", $time, irqOut, e);
            num_errors++;
        end
    endtask : chkIrq

    task automatic wb(input logic w, input logic [7:0] a, input int d,
            input logic [3:0] s);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatWr <= 32'(d);
        wbSel <= s;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (wbAck !== 1'b1) begin
            $display("Error t=%0t got %h exp %h", $time, wbAck, 1'b1);
            num_errors++;
        end
        q = wbDatRd;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge ref_clk);
    endtask : wb

    task automatic rd(input logic [7:0] a, input int e);
        wb(1'b0, a, 0, 4'hF);
        chk(q, e);
    endtask : rd

    task automatic ev(input int k);
        evKind <= 3'(k);
        evGo <= 1'b1;
        @(posedge ref_clk);
        evGo <= 1'b0;
        repeat (6) @(posedge ref_clk);
        expF |= evBit[k] & impl;
        expS |= evBit[k] & impl;
    endtask : ev

    initial begin
        #200000;
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int a = 0; a <= 'h14; a += 4) rd(8'(a), 0);
        wb(1'b1, 8'h14, 'hFF, 4'hF);
        rd(`ADDR_FLAGS, 0);
        for (int k = 0; k < 8; k++) begin
            ev(k);
            rd(`ADDR_FLAGS, expF);
            rd(`ADDR_EVT_STATUS, expS);
            expS = 0;
            rd(`ADDR_EVT_STATUS, expS);
            rd(`ADDR_FLAGS, expF);
            wb(1'b1, `ADDR_FLAGS, 0, 4'h1);
            expF = 0;
            rd(`ADDR_FLAGS, 0);
        end
        // flags were cleared above, before any enable is set
        wb(1'b1, `ADDR_FLAG_EN, 'h01, 4'h1);
        wb(1'b1, `ADDR_CTRL, 'h03, 4'h1);
        ev(6);
        chkIrq(1'b1);
        wb(1'b1, `ADDR_CTRL, 'h01, 4'h1);
        repeat (2) @(posedge ref_clk);
        chkIrq(1'b0);
        wb(1'b1, `ADDR_CTRL, 'h03, 4'h1);
        wb(1'b1, `ADDR_FLAGS, 0, 4'h1);
        expF = 0;
        wb(1'b1, `ADDR_EVT_MASK, 'h08, 4'h1);
        repeat (2) @(posedge ref_clk);
        chkIrq(1'b0);
        ev(4);
        chkIrq(1'b1);
        rd(`ADDR_EVT_STATUS, expS);
        expS = 0;
        repeat (2) @(posedge ref_clk);
        chkIrq(1'b0);
        wb(1'b1, `ADDR_FLAGS, 0, 4'h1);
        expF = 0;
        for (int i = 0; i < 8; i++) begin
            expF = $random(seed) & 'hFF;
            wb(1'b1, `ADDR_FLAGS, expF, 4'h1);
            expF &= impl;
            rd(`ADDR_FLAGS, expF);
        end
        // byte lane 0 off: write ignored
        wb(1'b1, `ADDR_FLAGS, ~expF & 'hFF, 4'hE);
        rd(`ADDR_FLAGS, expF);
        reducedStrap <= 1'b1;
        impl = 'h19;
        repeat (4) @(posedge ref_clk);
        rd(`ADDR_FLAGS, expF & impl);
        wb(1'b1, `ADDR_FLAGS, 'hFF, 4'h1);
        rd(`ADDR_FLAGS, 'h19);
        wb(1'b1, `ADDR_FLAGS, 0, 4'h1);
        expF = 0;
        ev(0);
        rd(`ADDR_FLAGS, expF);
        end_sim();
    end
endmodule : tb

`default_nettype wire
